// file: rtl/periph_irq_flags.sv
/*
  Peripheral interrupt enable and request registers with APB slave and
  the gated interrupt request to the core.
  Assumes event inputs synchronous to pclk; the second and third request
  registers live outside and arrive as plain flag vectors.
*/
// What this block does
// - no peripheral interrupt reaches the core unless peripheral master enable is set.
// - flags set on their condition regardless of enable or global enable.
// - second enable register: osc fail, comp2, comp1, eeprom, collision, lcd, -, capcomp2.
// - third enable register: capcomp 5,4,3 at bits 6..4, timer6 bit 3, timer4 bit 1.
// - unimplemented enable bits always read zero.
// - all implemented bits reset to zero on any reset.
// - timer1 gate flag is one while gate inactive, zero while active.
// - converter flag sets when a conversion completes.
// - receive flag is read-only, mirrors receive buffer full.
// - transmit flag is read-only, mirrors transmit buffer empty.
// - sync serial flag sets when a transfer completes.
// - capcomp1 flag sets on capture or compare per mode, unused in pulse-width.
// - timer2 flag sets when timer2 count matches its period.
// - timer1 overflow flag sets when timer1 count overflows.
// - writable flags other than the gate flag stay set until software writes zero.
// - each enable bit passes or blocks its own interrupt.
// - global enable zero blocks all; one allows enabled ones.
`timescale 1ns/10ps
module periph_irq_flags
  import periph_irq_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire event_type   events,
  input  wire logic [7:0]  request_b_flags,
  input  wire logic [7:0]  request_c_flags,
  output logic             irq
);

  // ==========================================================
  // state and bus decode
  state_type state;
  state_type next_state;

  logic       bus_setup;
  logic       bus_write;
  logic       addr_mapped;
  logic [7:0] write_byte;
  logic [7:0] read_mux;
  logic [7:0] pending;

  // frozen clock enable stalls the access phase
  assign pready    = clk_en;
  assign bus_setup = psel & ~penable;
  assign bus_write = psel & penable & pwrite & pstrb[0] & clk_en;
  assign write_byte = pwdata[7:0];

  always_comb begin
    addr_mapped = 1'b1;
    read_mux    = RESET_BYTE;
    case (paddr)
      OFF_ENABLE_A:  read_mux = state.enable_a;
      OFF_ENABLE_B:  read_mux = state.enable_b;
      OFF_ENABLE_C:  read_mux = state.enable_c;
      OFF_REQUEST_A: read_mux = state.request_a;
      OFF_CONTROL: begin
        read_mux[GIE_BIT]  = state.control.global_irq_enable;
        read_mux[PERIPH_IRQ_MASTER_ENABLE_BIT] = state.control.periph_irq_master_enable;
      end
      default:       addr_mapped = 1'b0;
    endcase
  end

  // ==========================================================
  // next state
  always_comb begin
    next_state = state;
    if (clk_en) begin
      if (bus_write) begin
        case (paddr)
          OFF_ENABLE_A: next_state.enable_a = write_byte & ENABLE_A_MASK;
          OFF_ENABLE_B: next_state.enable_b = write_byte & ENABLE_B_MASK;
          OFF_ENABLE_C: next_state.enable_c = write_byte & ENABLE_C_MASK;
          OFF_REQUEST_A: begin
            next_state.request_a = (state.request_a & ~REQUEST_A_WMASK)
                                 | (write_byte & REQUEST_A_WMASK);
          end
          OFF_CONTROL: begin
            next_state.control.global_irq_enable        = write_byte[GIE_BIT];
            next_state.control.periph_irq_master_enable = write_byte[PERIPH_IRQ_MASTER_ENABLE_BIT];
          end
          default: ;
        endcase
      end

      // hardware sets follow the write so they win over a clear
      // set beats clear
      next_state.request_a[GATE_BIT] = ~events.gate_active;
      if (events.conv_done) begin
        next_state.request_a[CONV_BIT] = 1'b1;
      end
      next_state.request_a[RXFULL_BIT]  = events.rx_buffer_full;
      next_state.request_a[TXEMPTY_BIT] = events.tx_buffer_empty;
      if (events.sync_xfer_done) begin
        next_state.request_a[SYNC_BIT] = 1'b1;
      end
      case (events.capcomp_mode)
        MODE_CAPTURE: begin
          if (events.capture_event) begin
            next_state.request_a[CAPCOMP_BIT] = 1'b1;
          end
        end
        MODE_COMPARE: begin
          if (events.compare_event) begin
            next_state.request_a[CAPCOMP_BIT] = 1'b1;
          end
        end
        default: ;
      endcase
      if (events.timer_two_match) begin
        next_state.request_a[T2MATCH_BIT] = 1'b1;
      end
      if (events.timer_one_overflow) begin
        next_state.request_a[T1OVF_BIT] = 1'b1;
      end

      // read data captured in setup so it comes from a flop
      if (bus_setup) begin
        next_state.read_byte  = addr_mapped ? read_mux : RESET_BYTE;
        next_state.read_error = ~addr_mapped;
      end
    end
  end

  // ==========================================================
  // registers
  // every bit resets to zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= STATE_RESET;
    end else begin
      state <= next_state;
    end
  end

  assign prdata  = {24'h000000, state.read_byte};
  assign pslverr = state.read_error;

  // ==========================================================
  // interrupt gating
  // per-source enable
  assign pending = (state.request_a & state.enable_a)
                 | (request_b_flags & state.enable_b)
                 | (request_c_flags & state.enable_c);

  assign irq = state.control.global_irq_enable
             & state.control.periph_irq_master_enable
             & (|pending);

  // ==========================================================
  // assertions
  logic request_write;
  assign request_write = bus_write & (paddr == OFF_REQUEST_A);

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  periph_gate_a: assert property (
    !state.control.periph_irq_master_enable |-> !irq)
    else $error("interrupt raised with peripheral master enable clear");

  global_gate_a: assert property (
    !state.control.global_irq_enable |-> !irq)
    else $error("interrupt raised with global enable clear");

  source_enable_a: assert property (
    (state.control.global_irq_enable && state.control.periph_irq_master_enable
     && state.enable_b[7] && request_b_flags[7]) |-> irq)
    else $error("enabled pending source did not raise interrupt");

  flag_ignores_en_a: assert property (
    (clk_en && events.conv_done && !state.control.global_irq_enable)
      |=> state.request_a[CONV_BIT])
    else $error("flag not set while enables were off");

  unused_zero_a: assert property (
    !state.enable_b[1] && !state.enable_c[7] && !state.enable_c[2]
      && !state.enable_c[0])
    else $error("unimplemented enable bit became one");

  reset_clear_a: assert property (
    $rose(presetn) |-> (state.enable_b == RESET_BYTE && state.enable_c == RESET_BYTE
                        && state.request_a == RESET_BYTE))
    else $error("register not zero after reset");

  gate_level_a: assert property (
    clk_en |=> state.request_a[GATE_BIT] == !$past(events.gate_active))
    else $error("gate flag does not follow gate level");

  buffer_mirror_a: assert property (
    clk_en |=> (state.request_a[RXFULL_BIT] == $past(events.rx_buffer_full)
                && state.request_a[TXEMPTY_BIT] == $past(events.tx_buffer_empty)))
    else $error("buffer flags do not mirror buffer state");

  sync_done_a: assert property (
    clk_en && events.sync_xfer_done |=> state.request_a[SYNC_BIT])
    else $error("serial flag not set on transfer completion");

  capcomp_mode_a: assert property (
    (clk_en && events.capture_event && events.capcomp_mode == MODE_CAPTURE)
      |=> state.request_a[CAPCOMP_BIT])
    else $error("capture did not set capcomp flag");

  pwm_unused_a: assert property (
    (clk_en && events.capcomp_mode == MODE_PULSE_WIDTH && !request_write)
      |=> state.request_a[CAPCOMP_BIT] == $past(state.request_a[CAPCOMP_BIT]))
    else $error("capcomp flag changed in pulse-width mode");

  timer_flags_a: assert property (
    (clk_en && events.timer_two_match) |=> state.request_a[T2MATCH_BIT])
    else $error("timer2 flag not set on period match");

  timer_overflow_a: assert property (
    (clk_en && events.timer_one_overflow) |=> state.request_a[T1OVF_BIT])
    else $error("timer1 flag not set on overflow");

  flag_sticky_a: assert property (
    (state.request_a[CONV_BIT] && !(request_write && !pwdata[CONV_BIT]))
      |=> state.request_a[CONV_BIT])
    else $error("converter flag cleared without software write");

  set_wins_a: assert property (
    (request_write && !pwdata[T1OVF_BIT] && events.timer_one_overflow)
      |=> state.request_a[T1OVF_BIT])
    else $error("same-cycle set lost to software clear");

  read_answer_a: assert property (
    (psel && !penable && clk_en && paddr == OFF_REQUEST_A)
      |=> prdata[7:0] == $past(state.request_a) && !pslverr)
    else $error("read data does not match request register");

  unmapped_error_a: assert property (
    (bus_setup && clk_en && !addr_mapped) |=> pslverr && prdata == 32'h00000000)
    else $error("unmapped address answered without error");

  // a stalled bus must leave every register untouched
  freeze_state_a: assert property (
    !clk_en |=> state == $past(state))
    else $error("state moved while clock enable was low");

  conv_done_a: assert property (
    (clk_en && events.conv_done) |=> state.request_a[CONV_BIT])
    else $error("converter flag not set on conversion complete");

  conv_idle_a: assert property (
    (!state.request_a[CONV_BIT] && !events.conv_done
     && !(request_write && pwdata[CONV_BIT]))
      |=> !state.request_a[CONV_BIT])
    else $error("converter flag rose without a conversion");

  sync_idle_a: assert property (
    (!state.request_a[SYNC_BIT] && !events.sync_xfer_done
     && !(request_write && pwdata[SYNC_BIT]))
      |=> !state.request_a[SYNC_BIT])
    else $error("serial flag rose while waiting to transfer");

  compare_mode_a: assert property (
    (clk_en && events.compare_event && events.capcomp_mode == MODE_COMPARE)
      |=> state.request_a[CAPCOMP_BIT])
    else $error("compare match did not set capcomp flag");

  rx_readonly_a: assert property (
    (request_write && !pwdata[RXFULL_BIT] && events.rx_buffer_full)
      |=> state.request_a[RXFULL_BIT])
    else $error("software write changed the receive flag");

  flag_clear_a: assert property (
    (request_write && !pwdata[T2MATCH_BIT] && !events.timer_two_match)
      |=> !state.request_a[T2MATCH_BIT])
    else $error("timer2 flag not cleared by software write of zero");

  enable_b_write_a: assert property (
    (bus_write && paddr == OFF_ENABLE_B)
      |=> state.enable_b == ($past(pwdata[7:0]) & ENABLE_B_MASK))
    else $error("second enable register did not take written bits");

  enable_c_write_a: assert property (
    (bus_write && paddr == OFF_ENABLE_C)
      |=> state.enable_c == ($past(pwdata[7:0]) & ENABLE_C_MASK))
    else $error("third enable register did not take written bits");

  control_write_a: assert property (
    (bus_write && paddr == OFF_CONTROL)
      |=> state.control.global_irq_enable == $past(pwdata[GIE_BIT]))
    else $error("global enable did not take written value");

  master_write_a: assert property (
    (bus_write && paddr == OFF_CONTROL)
      |=> state.control.periph_irq_master_enable == $past(pwdata[PERIPH_IRQ_MASTER_ENABLE_BIT]))
    else $error("peripheral master enable did not take written value");

  request_a_irq_a: assert property (
    (state.control.global_irq_enable && state.control.periph_irq_master_enable
     && state.enable_a[T1OVF_BIT] && state.request_a[T1OVF_BIT]) |-> irq)
    else $error("enabled timer1 flag did not raise interrupt");

  enable_c_irq_a: assert property (
    (state.control.global_irq_enable && state.control.periph_irq_master_enable
     && state.enable_c[1] && request_c_flags[1]) |-> irq)
    else $error("timer4 enable did not pass its request");

  enable_block_a: assert property (
    (state.enable_a == RESET_BYTE && state.enable_b == RESET_BYTE
     && state.enable_c == RESET_BYTE) |-> !irq)
    else $error("interrupt raised with every enable clear");

  irq_raised_c: cover property (!irq ##1 irq);
  flag_cleared_c: cover property (request_write ##1 !state.request_a[CONV_BIT]);
  set_clear_race_c: cover property (request_write && events.timer_one_overflow);
  bad_address_c: cover property (psel && penable && pslverr);
  pending_blocked_c: cover property ((|pending) && !irq);

endmodule

// file: rtl/periph_irq_pkg.sv
/*
  Package for the peripheral interrupt enable and request block:
  register offsets, field positions, write masks, reset values, carriers.
  Assumes a 32-bit APB bus with 8-bit registers in the low byte lane.
*/
package periph_irq_pkg;

  // ==========================================================
  // register map (byte addresses)
  localparam logic [11:0] OFF_ENABLE_A  = 12'h000;
  localparam logic [11:0] OFF_ENABLE_B  = 12'h004;
  localparam logic [11:0] OFF_ENABLE_C  = 12'h008;
  localparam logic [11:0] OFF_REQUEST_A = 12'h00C;
  localparam logic [11:0] OFF_CONTROL   = 12'h010;

  // ==========================================================
  // implemented and writable bits
  localparam logic [7:0] ENABLE_A_MASK  = 8'hFF;
  localparam logic [7:0] ENABLE_B_MASK  = 8'hFD;
  localparam logic [7:0] ENABLE_C_MASK  = 8'h7A;
  localparam logic [7:0] REQUEST_A_WMASK = 8'hCF;
  localparam logic [7:0] RESET_BYTE     = 8'h00;

  // ==========================================================
  // request register bit positions
  localparam int unsigned GATE_BIT    = 7;
  localparam int unsigned CONV_BIT    = 6;
  localparam int unsigned RXFULL_BIT  = 5;
  localparam int unsigned TXEMPTY_BIT = 4;
  localparam int unsigned SYNC_BIT    = 3;
  localparam int unsigned CAPCOMP_BIT = 2;
  localparam int unsigned T2MATCH_BIT = 1;
  localparam int unsigned T1OVF_BIT   = 0;

  // control register bit positions
  localparam int unsigned GIE_BIT  = 1;
  localparam int unsigned PERIPH_IRQ_MASTER_ENABLE_BIT = 0;

  // ==========================================================
  // carriers
  typedef enum logic [1:0] {
    MODE_CAPTURE,
    MODE_COMPARE,
    MODE_PULSE_WIDTH
  } capcomp_mode_type;

  typedef struct packed {
    logic             gate_active;
    logic             conv_done;
    logic             rx_buffer_full;
    logic             tx_buffer_empty;
    logic             sync_xfer_done;
    logic             capture_event;
    logic             compare_event;
    capcomp_mode_type capcomp_mode;
    logic             timer_two_match;
    logic             timer_one_overflow;
  } event_type;

  typedef struct packed {
    logic       global_irq_enable;
    logic       periph_irq_master_enable;
  } control_type;

  typedef struct packed {
    logic [7:0]  enable_a;
    logic [7:0]  enable_b;
    logic [7:0]  enable_c;
    logic [7:0]  request_a;
    control_type control;
    logic [7:0]  read_byte;
    logic        read_error;
  } state_type;

  localparam state_type STATE_RESET = '0;

endpackage

// file: tb/periph_irq_flags_tb.sv
/*
  Self-checking bench for the peripheral interrupt flag block over APB.
  Assumes zero-wait answers are not relied on: every access waits for pready.
*/
`timescale 1ns/10ps
module periph_irq_flags_tb;
  import periph_irq_pkg::*;
  logic        pclk, presetn, clk_en, psel, penable, pwrite, irq, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb;
  logic        er;
  event_type   events;
  logic [7:0]  request_b_flags, request_c_flags;
  int          failures, n_checks, cycles, ks[7];
  logic [7:0]  ex[7];

  periph_irq_flags u_periph_irq_flags (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .events(events),
    .request_b_flags(request_b_flags), .request_c_flags(request_c_flags), .irq(irq));
  periph_model u_periph_model (.pclk(pclk), .events(events),
    .request_b_flags(request_b_flags), .request_c_flags(request_c_flags));

  // ==========================================================
  // clock, reset, timeout
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures = failures + 1;
      end_of_test();
    end
  end

  // ==========================================================
  // shared tasks
  task automatic end_of_test();
    if (failures == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rchk(input logic [11:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    check(rd, {24'h000000, e});
  endtask
  task automatic irqchk(input logic e);
    @(negedge pclk);
    check({31'h0, irq}, {31'h0, e});
  endtask

  // ==========================================================
  // main sequence
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {failures, n_checks, cycles} = '0;
    clk_en = 1'b1;
    pstrb = 4'hF;
    ks = '{6, 3, 1, 0, 2, 4, 5};
    ex = '{8'h40, 8'h08, 8'h02, 8'h01, 8'h04, 8'h04, 8'h00};
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rchk(OFF_ENABLE_B, 8'h00);
    rchk(OFF_ENABLE_C, 8'h00);
    rchk(OFF_REQUEST_A, 8'h00);
    apb(1'b1, OFF_ENABLE_B, 8'hFF);
    rchk(OFF_ENABLE_B, 8'hFD);
    apb(1'b1, OFF_ENABLE_C, 8'hFF);
    rchk(OFF_ENABLE_C, 8'h7A);
    apb(1'b1, OFF_ENABLE_B, 8'h00);
    apb(1'b1, OFF_ENABLE_C, 8'h00);
    apb(1'b0, 12'h020, 8'h00);
    check({31'h0, er}, 32'h1);
    pstrb <= 4'h0;
    apb(1'b1, OFF_ENABLE_A, 8'hFF);
    pstrb <= 4'hF;
    rchk(OFF_ENABLE_A, 8'h00);
    // flags rise with all enables and control clear, except capcomp in pulse-width mode, then hold until cleared
    for (int i = 0; i < 7; i++) begin
      u_periph_model.pulse(ks[i]);
      rchk(OFF_REQUEST_A, ex[i]);
      repeat (5) @(posedge pclk);
      rchk(OFF_REQUEST_A, ex[i]);
      apb(1'b1, OFF_REQUEST_A, 8'h00);
      rchk(OFF_REQUEST_A, 8'h00);
    end
    u_periph_model.levels(1'b0, 1'b1, 1'b1);
    rchk(OFF_REQUEST_A, 8'hB0);
    apb(1'b1, OFF_REQUEST_A, 8'h00);
    rchk(OFF_REQUEST_A, 8'hB0);
    u_periph_model.levels(1'b1, 1'b0, 1'b0);
    rchk(OFF_REQUEST_A, 8'h00);
    // a frozen block must miss an event pulsed while clk_en is low
    @(posedge pclk);
    clk_en <= 1'b0;
    u_periph_model.pulse(0);
    clk_en <= 1'b1;
    rchk(OFF_REQUEST_A, 8'h00);
    u_periph_model.pulse(0);
    fork
      apb(1'b1, OFF_REQUEST_A, 8'h00);
      begin
        @(posedge pclk);
        u_periph_model.pulse(0);
      end
    join
    rchk(OFF_REQUEST_A, 8'h01);
    // flag already pending before enable: software clears it first
    apb(1'b1, OFF_REQUEST_A, 8'h00);
    apb(1'b1, OFF_ENABLE_A, 8'h01);
    u_periph_model.pulse(0);
    for (int c = 0; c < 4; c++) begin
      apb(1'b1, OFF_CONTROL, c[7:0]);
      irqchk(c == 3);
    end
    apb(1'b1, OFF_ENABLE_A, 8'h00);
    irqchk(1'b0);
    u_periph_model.outer(8'h02, 8'h00);
    apb(1'b1, OFF_ENABLE_B, 8'hFF);
    irqchk(1'b0);
    u_periph_model.outer(8'h01, 8'h00);
    irqchk(1'b1);
    u_periph_model.outer(8'h80, 8'h00);
    irqchk(1'b1);
    apb(1'b1, OFF_ENABLE_B, 8'h00);
    u_periph_model.outer(8'h00, 8'h01);
    apb(1'b1, OFF_ENABLE_C, 8'hFF);
    irqchk(1'b0);
    u_periph_model.outer(8'h00, 8'h02);
    irqchk(1'b1);
    @(posedge pclk);
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    irqchk(1'b0);
    rchk(OFF_ENABLE_B, 8'h00);
    rchk(OFF_ENABLE_C, 8'h00);
    end_of_test();
  end
endmodule

// file: tb/periph_model.sv
/*
  Peripheral-side model: drives the event carrier and the outer request
  flag vectors as levels and one-cycle pulses, launched after a rising edge.
  Assumes the bench calls its tasks hierarchically from one process.
*/
`timescale 1ns/10ps
module periph_model
  import periph_irq_pkg::*;
(
  input  wire logic       pclk,
  output event_type       events,
  output logic      [7:0] request_b_flags,
  output logic      [7:0] request_c_flags
);
  // ==========================================================
  // idle state: gate active, buffers neither full nor empty
  initial begin
    events = '0;
    events.gate_active = 1'b1;
    request_b_flags = 8'h00;
    request_c_flags = 8'h00;
  end

  // ==========================================================
  // gate and buffer levels
  task automatic levels(input logic g, input logic rx, input logic tx);
    @(posedge pclk);
    events.gate_active <= g;
    events.rx_buffer_full <= rx;
    events.tx_buffer_empty <= tx;
  endtask

  task automatic outer(input logic [7:0] b, input logic [7:0] c);
    @(posedge pclk);
    request_b_flags <= b;
    request_c_flags <= c;
  endtask

  task automatic pulse(input int k);
    @(posedge pclk);
    case (k)
      6: events.conv_done <= 1'b1;
      3: events.sync_xfer_done <= 1'b1;
      1: events.timer_two_match <= 1'b1;
      0: events.timer_one_overflow <= 1'b1;
      2: begin
        events.capcomp_mode <= MODE_CAPTURE;
        events.capture_event <= 1'b1;
      end
      4: begin
        events.capcomp_mode <= MODE_COMPARE;
        events.compare_event <= 1'b1;
      end
      default: begin
        events.capcomp_mode <= MODE_PULSE_WIDTH;
        events.capture_event <= 1'b1;
        events.compare_event <= 1'b1;
      end
    endcase
    @(posedge pclk);
    events.conv_done <= 1'b0;
    events.sync_xfer_done <= 1'b0;
    events.timer_two_match <= 1'b0;
    events.timer_one_overflow <= 1'b0;
    events.capture_event <= 1'b0;
    events.compare_event <= 1'b0;
  endtask
endmodule
